/* File: logic/hti_cmd_unit.sv */
// I2C target command unit: protocol engine, command execution, response framing
// assumes scl_clk is the SCL pin used as clock, sda is open drain resolved outside
`timescale 1ns/100ps
`default_nettype none
module hti_cmd_unit
#(
  parameter logic [6:0]  DEV_ADDR      = 7'h40,          // arbitrary default
  parameter logic [31:0] SERIAL_NUMBER = 32'h1234_5678,  // arbitrary, fixed at build
  parameter int unsigned MEAS_LO_CYC   = hti_pkg::T_MEAS_LO_US * hti_pkg::CLK_MHZ,
  parameter int unsigned MEAS_MD_CYC   = hti_pkg::T_MEAS_MD_US * hti_pkg::CLK_MHZ,
  parameter int unsigned MEAS_HI_CYC   = hti_pkg::T_MEAS_HI_US * hti_pkg::CLK_MHZ,
  parameter int unsigned HEAT_LG_CYC   = hti_pkg::T_HEAT_LG_US * hti_pkg::CLK_MHZ,
  parameter int unsigned HEAT_SH_CYC   = hti_pkg::T_HEAT_SH_US * hti_pkg::CLK_MHZ,
  parameter int unsigned RESET_CYC     = hti_pkg::T_RESET_US * hti_pkg::CLK_MHZ
)
(
  // core clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // link clock and pins
  input  wire logic        scl_clk,
  input  wire logic        sda_in,
  output var  logic        sda_out,
  output var  logic        sda_oe,
  // sensing front end
  input  wire logic [15:0] temp_raw_word,
  input  wire logic [15:0] humidity_raw_word,
  output var  logic        meas_active,
  output var  logic [1:0]  meas_rep,
  // heater and status
  output var  logic        heater_on,
  output var  logic [1:0]  heater_power,
  output var  logic        busy
);

  localparam logic [hti_pkg::TMR_W-1:0] M_LO = hti_pkg::TMR_W'(MEAS_LO_CYC - 1);
  localparam logic [hti_pkg::TMR_W-1:0] M_MD = hti_pkg::TMR_W'(MEAS_MD_CYC - 1);
  localparam logic [hti_pkg::TMR_W-1:0] M_HI = hti_pkg::TMR_W'(MEAS_HI_CYC - 1);
  // heating plus closing measurement fits inside the pulse length
  localparam logic [hti_pkg::TMR_W-1:0] H_LG = hti_pkg::TMR_W'(HEAT_LG_CYC - MEAS_HI_CYC - 1);
  localparam logic [hti_pkg::TMR_W-1:0] H_SH = hti_pkg::TMR_W'(HEAT_SH_CYC - MEAS_HI_CYC - 1);
  localparam logic [hti_pkg::TMR_W-1:0] R_TM = hti_pkg::TMR_W'(RESET_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // link domain: sample SDA on rising SCL, signal each bit by a toggle

  logic link_rst_s1_reg;
  logic link_rst_s2_reg;
  logic link_bit_reg;
  logic link_tog_reg;

  always_ff @(posedge scl_clk)
  begin
    link_rst_s1_reg <= rstn;
    link_rst_s2_reg <= link_rst_s1_reg;
  end

  // bit stays put until the next rising edge, long after the core has taken it
  always_ff @(posedge scl_clk)
  begin
    if (!link_rst_s2_reg)
    begin
      link_bit_reg <= 1'b1;
      link_tog_reg <= 1'b0;
    end
    else
    begin
      link_bit_reg <= sda_in;
      link_tog_reg <= ~link_tog_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core domain: synchronisers and bus events

  logic [2:0] tog_s_reg;
  logic [1:0] scl_s_reg;
  logic [1:0] sda_s_reg;
  logic       scl_d_reg;
  logic       sda_d_reg;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      tog_s_reg <= 3'h0;
      scl_s_reg <= 2'h3;
      sda_s_reg <= 2'h3;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      tog_s_reg <= {tog_s_reg[1:0], link_tog_reg};
      scl_s_reg <= {scl_s_reg[0], scl_clk};
      sda_s_reg <= {sda_s_reg[0], sda_in};
      scl_d_reg <= scl_s_reg[1];
      sda_d_reg <= sda_s_reg[1];
    end
  end

  logic bit_ev;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  assign bit_ev   = tog_s_reg[2] ^ tog_s_reg[1];
  assign scl_fall = scl_d_reg & ~scl_s_reg[1];
  assign start_ev = scl_s_reg[1] & scl_d_reg & sda_d_reg & ~sda_s_reg[1];
  assign stop_ev  = scl_s_reg[1] & scl_d_reg & ~sda_d_reg & sda_s_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // response store

  typedef enum logic [1:0] {
    E_IDLE = 2'b00,
    E_HEAT = 2'b01,
    E_MEAS = 2'b10,
    E_RST  = 2'b11
  } hti_exec_t;

  hti_exec_t  ex_reg;
  logic [15:0] word_reg [2];
  logic [7:0]  crc_w [2];
  logic [7:0]  crc_reg [2];
  logic        valid_reg;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_crc
      hti_crc8 u_crc (
        .word (word_reg[gi]),
        .crc  (crc_w[gi])
      );
      always_ff @(posedge core_clk)
      begin
        if (!rstn)
          crc_reg[gi] <= hti_pkg::CRC_INIT;
        else
          crc_reg[gi] <= crc_w[gi];                             // [R3]
      end
    end
  endgenerate

  // data hi, data lo, checksum per word; padding past the last byte
  function automatic logic [7:0] resp_byte(input logic [2:0] idx);
    case (idx)
      3'h0:    resp_byte = word_reg[0][15:8];                   // [R18]
      3'h1:    resp_byte = word_reg[0][7:0];
      3'h2:    resp_byte = crc_reg[0];                          // [R1]
      3'h3:    resp_byte = word_reg[1][15:8];
      3'h4:    resp_byte = word_reg[1][7:0];
      3'h5:    resp_byte = crc_reg[1];                          // [R1]
      default: resp_byte = hti_pkg::IDLE_BYTE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // protocol engine

  typedef enum logic [2:0] {
    P_IDLE = 3'b000,
    P_RX   = 3'b001,
    P_ACKW = 3'b010,
    P_ACK  = 3'b011,
    P_TX   = 3'b100,
    P_MACK = 3'b101,
    P_TXL  = 3'b110
  } hti_prot_t;

  hti_prot_t  pr_reg;
  logic [7:0] sr_reg;
  logic [3:0] cnt_reg;
  logic [2:0] idx_reg;
  logic       addr_ph_reg;
  logic       rd_reg;
  logic       gc_reg;
  logic       ack_reg;
  logic       cmd_stb_reg;
  logic [7:0] cmd_reg;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;

  assign rx_byte = {sr_reg[6:0], link_bit_reg};
  assign tx_byte = resp_byte(idx_reg);

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      pr_reg      <= P_IDLE;
      sr_reg      <= 8'h00;
      cnt_reg     <= 4'h0;
      idx_reg     <= 3'h0;
      addr_ph_reg <= 1'b0;
      rd_reg      <= 1'b0;
      gc_reg      <= 1'b0;
      ack_reg     <= 1'b0;
      cmd_stb_reg <= 1'b0;
      cmd_reg     <= 8'h00;
      sda_oe      <= 1'b0;
    end
    else
    begin
      cmd_stb_reg <= 1'b0;
      if (start_ev)
      begin
        pr_reg      <= P_RX;
        cnt_reg     <= 4'h0;
        idx_reg     <= 3'h0;
        addr_ph_reg <= 1'b1;
        sda_oe      <= 1'b0;
      end
      else if (stop_ev)
      begin
        pr_reg <= P_IDLE;
        sda_oe <= 1'b0;
      end
      else
      begin
        unique case (pr_reg)
          P_IDLE: ;
          P_RX:
            if (bit_ev)
            begin
              sr_reg  <= rx_byte;
              cnt_reg <= cnt_reg + 4'h1;
              if (cnt_reg == hti_pkg::BITS_BYTE - 4'h1)
              begin
                pr_reg <= P_ACKW;
                if (addr_ph_reg)
                begin
                  rd_reg <= rx_byte[0];
                  gc_reg <= rx_byte[7:1] == hti_pkg::GC_ADDR;
                  // read header refused while executing or with nothing to send
                  ack_reg <= (rx_byte[7:1] == DEV_ADDR &&
                              !(rx_byte[0] && (ex_reg != E_IDLE || !valid_reg))) || // [R10]
                             (rx_byte == {hti_pkg::GC_ADDR, 1'b0});
                end
                else
                begin
                  ack_reg     <= 1'b1;
                  cmd_stb_reg <= 1'b1;
                  cmd_reg     <= gc_reg ? (rx_byte == hti_pkg::GC_RESET ?          // [R21]
                                 hti_pkg::CMD_SOFT_RST : 8'h00) : rx_byte;
                end
              end
            end
          P_ACKW:
            if (scl_fall)
            begin
              if (ack_reg)
              begin
                pr_reg <= P_ACK;
                sda_oe <= 1'b1;
              end
              else
                pr_reg <= P_IDLE;
            end
          P_ACK:
            if (scl_fall)
            begin
              addr_ph_reg <= 1'b0;
              cnt_reg     <= 4'h0;
              if (rd_reg)
              begin
                pr_reg  <= P_TX;
                sr_reg  <= tx_byte;
                sda_oe  <= ~tx_byte[7];                         // [R18]
              end
              else
              begin
                pr_reg <= P_RX;
                sda_oe <= 1'b0;
              end
            end
          P_TX:
          begin
            if (bit_ev)
              cnt_reg <= cnt_reg + 4'h1;
            if (scl_fall)
            begin
              if (cnt_reg == hti_pkg::BITS_BYTE)
              begin
                pr_reg <= P_MACK;
                sda_oe <= 1'b0;
              end
              else
              begin
                sda_oe <= ~sr_reg[6];
                sr_reg <= {sr_reg[6:0], 1'b1};
              end
            end
          end
          P_MACK:
            if (bit_ev)
            begin
              // a not-acknowledge after any byte ends the read cleanly
              if (link_bit_reg)
                pr_reg <= P_IDLE;                               // [R5]
              else
              begin
                pr_reg  <= P_TXL;
                idx_reg <= idx_reg + 3'h1;
              end
            end
          P_TXL:
            if (scl_fall)
            begin
              pr_reg  <= P_TX;
              cnt_reg <= 4'h0;
              sr_reg  <= tx_byte;                               // [R1] [R2]
              sda_oe  <= ~tx_byte[7];
            end
          default: pr_reg <= P_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    sda_out <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // command execution

  hti_pkg::hti_cmd_t            dec;
  logic [hti_pkg::TMR_W-1:0]    tmr_reg;
  logic [1:0]                   rep_reg;

  assign dec = hti_pkg::hti_decode(cmd_reg);

  function automatic logic [hti_pkg::TMR_W-1:0] meas_len(input logic [1:0] r);
    unique case (r)
      hti_pkg::HTI_REP_LO: meas_len = M_LO;
      hti_pkg::HTI_REP_MD: meas_len = M_MD;
      default:             meas_len = M_HI;
    endcase
  endfunction

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      ex_reg       <= E_IDLE;
      tmr_reg      <= '0;
      rep_reg      <= hti_pkg::HTI_REP_HI;
      valid_reg    <= 1'b0;
      heater_on    <= 1'b0;
      heater_power <= hti_pkg::HTI_PWR_OFF;
      word_reg[0]  <= 16'h0000;
      word_reg[1]  <= 16'h0000;
    end
    else if (cmd_stb_reg && dec.kind == hti_pkg::HTI_K_RESET)
    begin
      ex_reg       <= E_RST;                                    // [R17] [R21]
      tmr_reg      <= R_TM;
      valid_reg    <= 1'b0;
      heater_on    <= 1'b0;
      heater_power <= hti_pkg::HTI_PWR_OFF;
    end
    else
    begin
      unique case (ex_reg)
        E_IDLE:
          if (cmd_stb_reg)
          begin
            unique case (dec.kind)
              hti_pkg::HTI_K_MEAS:
              begin
                ex_reg    <= E_MEAS;                            // [R6]
                rep_reg   <= dec.rep;
                tmr_reg   <= meas_len(dec.rep);                 // [R19]
                valid_reg <= 1'b0;
              end
              hti_pkg::HTI_K_SERIAL:
              begin
                word_reg[0] <= SERIAL_NUMBER[31:16];            // [R7] [R16]
                word_reg[1] <= SERIAL_NUMBER[15:0];
                valid_reg   <= 1'b1;
              end
              hti_pkg::HTI_K_HEAT:
              begin
                ex_reg       <= E_HEAT;                         // [R11]
                heater_on    <= 1'b1;
                heater_power <= dec.pwr;
                rep_reg      <= hti_pkg::HTI_REP_HI;
                tmr_reg      <= dec.long_pulse ? H_LG : H_SH;   // [R8] [R9] [R13]
                valid_reg    <= 1'b0;
              end
              default: ;
            endcase
          end
        E_HEAT:
          if (tmr_reg == '0)
          begin
            ex_reg  <= E_MEAS;                                  // heater stays on [R11]
            tmr_reg <= M_HI;
          end
          else
            tmr_reg <= tmr_reg - 1'b1;
        E_MEAS:
          if (tmr_reg == '0)
          begin
            ex_reg       <= E_IDLE;
            word_reg[0]  <= temp_raw_word;                      // [R2]
            word_reg[1]  <= humidity_raw_word;
            valid_reg    <= 1'b1;                               // [R19]
            heater_on    <= 1'b0;                               // [R12]
            heater_power <= hti_pkg::HTI_PWR_OFF;
          end
          else
            tmr_reg <= tmr_reg - 1'b1;
        E_RST:
          if (tmr_reg == '0)
            ex_reg <= E_IDLE;                                   // [R20]
          else
            tmr_reg <= tmr_reg - 1'b1;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      meas_active <= 1'b0;
      meas_rep    <= hti_pkg::HTI_REP_HI;
      busy        <= 1'b0;
    end
    else
    begin
      meas_active <= ex_reg == E_MEAS;
      meas_rep    <= rep_reg;
      busy        <= ex_reg != E_IDLE;                          // [R10]
    end
  end

endmodule
`default_nettype wire

/* File: logic/hti_pkg.sv */
// constants, types and decode helpers for the humidity/temperature command unit
// assumes a 25 MHz core clock and an I2C target port clocked by SCL
// Functional notes
// R1: read data goes out in bytes, a checksum byte after each data byte pair
// R2: measurement answer is temperature word plus checksum, then humidity word plus checksum
// R3: each checksum covers exactly the two-byte word sent just before it
// R4: checksum is CRC-8, polynomial 0x31, init 0xFF, no reflection, no final xor
// R5: controller may end a read after any word, skipping its checksum
// R6: 0xFD, 0xF6, 0xE0 measure at high, medium, low repeatability; six bytes back
// R7: 0x89 returns serial number as two words, each with its checksum
// R8: 0x39, 0x2F, 0x1E run one-second heater pulse at high, middle, low power
// R9: 0x32, 0x24, 0x15 run tenth-second heater pulse at high, middle, low power
// R10: read header is not acknowledged while a command is still executing
// R11: heater command turns heater on, counts down, then measures with heater on
// R12: when closing measurement ends, heater goes off, then result becomes readable
// R13: heater on-time at most one second; no heater-off command exists
// R14: controller keeps heater duty under ten percent and repeats pulses itself
// R15: host scales raw words over full 16-bit range into humidity and Celsius
// R16: serial number is fixed production storage, no command can change it
// R17: 0x94 is soft reset: acknowledged, no data, unit returns to idle
// R18: checksum fed and words sent most significant byte and bit first
// R19: measurement ends within 1.6, 4.5, 8.3 ms for low, medium, high
// R20: after soft or general-call reset, idle again within one millisecond
// R21: byte 0x06 to general call address 0x00 also resets the unit
package hti_pkg;

  // clock and times
  localparam int unsigned CLK_MHZ      = 25;
  localparam int unsigned T_MEAS_LO_US = 1600;
  localparam int unsigned T_MEAS_MD_US = 4500;
  localparam int unsigned T_MEAS_HI_US = 8300;
  localparam int unsigned T_HEAT_LG_US = 1000000;
  localparam int unsigned T_HEAT_SH_US = 100000;
  localparam int unsigned T_RESET_US   = 1000;
  localparam int unsigned TMR_W        = 25;

  // checksum
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  localparam logic [7:0] CRC_XOR  = 8'h00;

  // bus addresses and command bytes
  localparam logic [6:0] GC_ADDR      = 7'h00;
  localparam logic [7:0] GC_RESET     = 8'h06;
  localparam logic [7:0] CMD_MEAS_HI  = 8'hFD;
  localparam logic [7:0] CMD_MEAS_MD  = 8'hF6;
  localparam logic [7:0] CMD_MEAS_LO  = 8'hE0;
  localparam logic [7:0] CMD_SERIAL   = 8'h89;
  localparam logic [7:0] CMD_SOFT_RST = 8'h94;
  localparam logic [7:0] CMD_HT_HI_LG = 8'h39;
  localparam logic [7:0] CMD_HT_MD_LG = 8'h2F;
  localparam logic [7:0] CMD_HT_LO_LG = 8'h1E;
  localparam logic [7:0] CMD_HT_HI_SH = 8'h32;
  localparam logic [7:0] CMD_HT_MD_SH = 8'h24;
  localparam logic [7:0] CMD_HT_LO_SH = 8'h15;

  // response framing
  localparam logic [2:0] RESP_LAST = 3'h5;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;

  typedef enum logic [1:0] {
    HTI_PWR_OFF = 2'b00,
    HTI_PWR_LO  = 2'b01,
    HTI_PWR_MD  = 2'b10,
    HTI_PWR_HI  = 2'b11
  } hti_pwr_t;

  typedef enum logic [1:0] {
    HTI_REP_LO = 2'b00,
    HTI_REP_MD = 2'b01,
    HTI_REP_HI = 2'b10
  } hti_rep_t;

  typedef enum logic [2:0] {
    HTI_K_NONE   = 3'b000,
    HTI_K_MEAS   = 3'b001,
    HTI_K_SERIAL = 3'b010,
    HTI_K_RESET  = 3'b011,
    HTI_K_HEAT   = 3'b100
  } hti_kind_t;

  typedef struct packed {
    hti_kind_t kind;
    hti_rep_t  rep;
    hti_pwr_t  pwr;
    logic      long_pulse;
  } hti_cmd_t;

  function automatic hti_cmd_t hti_decode(input logic [7:0] b);
    hti_cmd_t c;
    c = '{kind: HTI_K_NONE, rep: HTI_REP_HI, pwr: HTI_PWR_OFF, long_pulse: 1'b0};
    case (b)
      CMD_MEAS_HI:  c.kind = HTI_K_MEAS;
      CMD_MEAS_MD:  begin c.kind = HTI_K_MEAS; c.rep = HTI_REP_MD; end
      CMD_MEAS_LO:  begin c.kind = HTI_K_MEAS; c.rep = HTI_REP_LO; end
      CMD_SERIAL:   c.kind = HTI_K_SERIAL;
      CMD_SOFT_RST: c.kind = HTI_K_RESET;
      CMD_HT_HI_LG: c = '{HTI_K_HEAT, HTI_REP_HI, HTI_PWR_HI, 1'b1};
      CMD_HT_MD_LG: c = '{HTI_K_HEAT, HTI_REP_HI, HTI_PWR_MD, 1'b1};
      CMD_HT_LO_LG: c = '{HTI_K_HEAT, HTI_REP_HI, HTI_PWR_LO, 1'b1};
      CMD_HT_HI_SH: c = '{HTI_K_HEAT, HTI_REP_HI, HTI_PWR_HI, 1'b0};
      CMD_HT_MD_SH: c = '{HTI_K_HEAT, HTI_REP_HI, HTI_PWR_MD, 1'b0};
      CMD_HT_LO_SH: c = '{HTI_K_HEAT, HTI_REP_HI, HTI_PWR_LO, 1'b0};
      default:      c.kind = HTI_K_NONE;
    endcase
    return c;
  endfunction

endpackage

/* File: logic/hti_crc8.sv */
// combinational CRC-8 over one 16-bit word
// assumes the caller registers the result
`timescale 1ns/100ps
`default_nettype none
module hti_crc8
(
  // word in
  input  wire logic [15:0] word,
  // checksum out
  output var  logic [7:0]  crc
);

  always_comb
  begin
    logic [7:0] c;
    c = hti_pkg::CRC_INIT;                                      // [R4]
    for (int i = 15; i >= 0; i--)                               // msb first [R18]
    begin
      if (c[7] ^ word[i])
        c = {c[6:0], 1'b0} ^ hti_pkg::CRC_POLY;                 // [R4]
      else
        c = {c[6:0], 1'b0};
    end
    crc = c ^ hti_pkg::CRC_XOR;                                 // [R3] [R4]
  end

endmodule
`default_nettype wire

/* File: tb/hti_cmd_unit_sva.sv */
// assertion checker for the humidity/temperature command unit
// assumes it is bound onto hti_cmd_unit; core_clk domain only
`timescale 1ns/100ps
`default_nettype none
module hti_cmd_unit_sva
#(
  parameter int unsigned MEAS_HI_CYC = 8,
  parameter int unsigned HEAT_LG_CYC = 16
)
(
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rstn,
  // status
  input wire logic       meas_active,
  input wire logic [1:0] meas_rep,
  input wire logic       heater_on,
  input wire logic [1:0] heater_power,
  input wire logic       busy,
  input wire logic       sda_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [31:0] heat_cnt, meas_cnt;
  always_ff @(posedge core_clk)
  begin
    heat_cnt <= (!rstn || !heater_on) ? 32'h0 : heat_cnt + 32'h1;
    meas_cnt <= (!rstn || !meas_active) ? 32'h0 : meas_cnt + 32'h1;
  end
  ////////////////////////////////////////////////////////////////
  property p_heat_pwr; heater_on |-> heater_power != 2'h0; endproperty
  a_heat_pwr: assert property (p_heat_pwr) else $error("heater on at zero power");
  property p_pwr_off; !heater_on |-> heater_power == 2'h0; endproperty
  a_pwr_off: assert property (p_pwr_off) else $error("power set with heater off");
  property p_heat_busy; $rose(heater_on) |-> ##[0:2] busy; endproperty
  a_heat_busy: assert property (p_heat_busy) else $error("heater without busy");
  property p_meas_busy; $rose(meas_active) |-> busy; endproperty
  a_meas_busy: assert property (p_meas_busy) else $error("measuring while idle");
  property p_heat_rep; heater_on && $rose(meas_active) |-> meas_rep == 2'h2; endproperty
  a_heat_rep: assert property (p_heat_rep) else $error("heater closing not high rep");
  property p_heat_end; $past(heater_on, 2) && $fell(meas_active) |-> !heater_on; endproperty
  a_heat_end: assert property (p_heat_end) else $error("heater left on after measure");
  property p_heat_max; heat_cnt <= HEAT_LG_CYC + 2; endproperty
  a_heat_max: assert property (p_heat_max) else $error("heater on too long");
  property p_meas_max; meas_cnt <= MEAS_HI_CYC + 2; endproperty
  a_meas_max: assert property (p_meas_max) else $error("measurement too long");
  property p_rep_hold; meas_active |=> $stable(meas_rep); endproperty
  a_rep_hold: assert property (p_rep_hold) else $error("rep changed mid measure");
  c_heat: cover property ($rose(heater_on));
  c_heat_meas: cover property (heater_on && $rose(meas_active));
  c_done: cover property ($fell(busy));
  c_ack: cover property ($rose(sda_oe));
endmodule
bind hti_cmd_unit hti_cmd_unit_sva #(.MEAS_HI_CYC(MEAS_HI_CYC), .HEAT_LG_CYC(HEAT_LG_CYC)) u_sva (
  .core_clk(core_clk), .rstn(rstn), .meas_active(meas_active), .meas_rep(meas_rep),
  .heater_on(heater_on), .heater_power(heater_power), .busy(busy), .sda_oe(sda_oe));
`default_nettype wire

/* File: tb/hti_host_model.sv */
// bus controller model driving scl and the low side of sda
// assumes the bench resolves sda with a pull-up
`timescale 1ns/100ps
`default_nettype none
module hti_host_model
(
  // link pins
  output var  logic scl_clk,
  output var  logic sda_low,
  input  wire logic sda_in
);
  localparam int HALF = 300;
  initial
  begin
    scl_clk = 1'b1;
    sda_low = 1'b0;
  end
  // sda moves well after scl falls so the unit sees no false start or stop
  task automatic bit_io(input logic b, output logic r);
    #100 sda_low <= ~b;
    #HALF scl_clk <= 1'b1;
    #HALF r = sda_in;
    scl_clk <= 1'b0;
  endtask
  task automatic start_c;
    sda_low <= 1'b1;
    #HALF scl_clk <= 1'b0;
  endtask
  task automatic stop_c;
    #100 sda_low <= 1'b1;
    #HALF scl_clk <= 1'b1;
    #HALF sda_low <= 1'b0;
    #HALF;
  endtask
  // sda stays released, so these pulses frame nothing
  task automatic idle_clocks(input int n);
    repeat (n)
    begin
      #HALF scl_clk <= 1'b0;
      #HALF scl_clk <= 1'b1;
    end
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, r);
  endtask
endmodule
`default_nettype wire

/* File: tb/hti_cmd_unit_tb.sv */
// self-checking bench for the command unit, controller model on the link
// assumes shortened counts; pull-up on sda
`timescale 1ns/100ps
`default_nettype none
module hti_cmd_unit_tb;
  localparam logic [6:0]  ADDR = 7'h45;
  localparam logic [31:0] SN   = 32'hA5C3_0F96; // arbitrary
  localparam int M_LO = 400, M_MD = 500, M_HI = 600, H_SH = 700, H_LG = 900, RST = 300;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] t_word = 16'h0;
  logic [15:0] h_word = 16'h0;
  logic scl_clk, sda_low, sda_out, sda_oe, meas_active, heater_on, busy;
  logic [1:0] meas_rep, heater_power;
  wire logic sda_in;
  int error_cnt = 0, num_checks = 0, busy_len = 0, busy_last = 0, heat_len = 0, heat_last = 0;
  assign sda_in = ~(sda_low | sda_oe);
  always #20 core_clk = ~core_clk;
  hti_host_model u_host (.scl_clk(scl_clk), .sda_low(sda_low), .sda_in(sda_in));
  hti_cmd_unit #(.DEV_ADDR(ADDR), .SERIAL_NUMBER(SN), .MEAS_LO_CYC(M_LO), .MEAS_MD_CYC(M_MD),
    .MEAS_HI_CYC(M_HI), .HEAT_LG_CYC(H_LG), .HEAT_SH_CYC(H_SH), .RESET_CYC(RST)) u_dut (
    .core_clk(core_clk), .rstn(rstn), .scl_clk(scl_clk), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .temp_raw_word(t_word), .humidity_raw_word(h_word),
    .meas_active(meas_active), .meas_rep(meas_rep), .heater_on(heater_on),
    .heater_power(heater_power), .busy(busy));
  always @(posedge core_clk)
  begin
    busy_len <= busy ? busy_len + 1 : 0;
    if (!busy && busy_len != 0) busy_last <= busy_len;
    heat_len <= heater_on ? heat_len + 1 : 0;
    if (!heater_on && heat_len != 0) heat_last <= heat_len;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction
  task automatic send(input logic [6:0] a, input logic [7:0] cmd);
    logic ack;
    u_host.start_c();
    u_host.wr_byte({a, 1'b0}, ack);
    check(ack, 1'b1);
    u_host.wr_byte(cmd, ack);
    check(ack, 1'b1);
    u_host.stop_c();
  endtask
  task automatic nack_read;
    logic ack;
    u_host.start_c();
    u_host.wr_byte({ADDR, 1'b1}, ack);
    check(ack, 1'b0);
    u_host.stop_c();
  endtask
  task automatic read_words(input logic [31:0] w, input int n);
    logic ack;
    logic [7:0] d;
    logic [47:0] exp;
    exp = {w[31:16], crc8(w[31:16]), w[15:0], crc8(w[15:0])};
    u_host.start_c();
    u_host.wr_byte({ADDR, 1'b1}, ack);
    check(ack, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      u_host.rd_byte(i == n - 1, d);
      check(d, exp[47 - 8 * i -: 8]);
    end
    u_host.stop_c();
  endtask
  task automatic wait_idle(output int n);
    for (n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge core_clk);
    check(busy, 1'b0);
    repeat (2) @(posedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic tc_measure;
    logic [7:0] cmds [3];
    int cyc [3];
    int n;
    cmds = '{hti_pkg::CMD_MEAS_LO, hti_pkg::CMD_MEAS_MD, hti_pkg::CMD_MEAS_HI};
    cyc = '{M_LO, M_MD, M_HI};
    for (int k = 0; k < 3; k++)
    begin
      @(posedge core_clk);
      t_word <= 16'hBEEF + 16'(k);
      h_word <= 16'h6A31 ^ 16'(k);
      send(ADDR, cmds[k]);
      nack_read();
      wait_idle(n);
      check(meas_rep, k);
      check(busy_last >= cyc[k] && busy_last <= cyc[k] + 4, 1'b1);
      read_words({16'hBEEF + 16'(k), 16'h6A31 ^ 16'(k)}, 6);
    end
  endtask
  task automatic tc_serial;
    send(ADDR, hti_pkg::CMD_SERIAL);
    check(crc8(16'hBEEF), 8'h92);
    check(sda_out, 1'b0);
    read_words(SN, 6);
  endtask
  task automatic tc_heater;
    logic [7:0] cmds [6];
    logic [1:0] pwr [6];
    int n;
    int len;
    cmds = '{hti_pkg::CMD_HT_HI_LG, hti_pkg::CMD_HT_MD_LG, hti_pkg::CMD_HT_LO_LG,
             hti_pkg::CMD_HT_HI_SH, hti_pkg::CMD_HT_MD_SH, hti_pkg::CMD_HT_LO_SH};
    pwr = '{2'h3, 2'h2, 2'h1, 2'h3, 2'h2, 2'h1};
    for (int k = 0; k < 6; k++)
    begin
      len = (k < 3) ? H_LG : H_SH;
      @(posedge core_clk);
      t_word <= 16'h1357 + 16'(k);
      h_word <= 16'hC0DE - 16'(k);
      send(ADDR, cmds[k]);
      check(heater_on, 1'b1);
      check(heater_power, pwr[k]);
      wait_idle(n);
      check(heater_on, 1'b0);
      check(heat_last >= len - 4 && heat_last <= len + 4, 1'b1);
      check(meas_rep, 2'h2);
      read_words({16'h1357 + 16'(k), 16'hC0DE - 16'(k)}, 2);
      read_words({16'h1357 + 16'(k), 16'hC0DE - 16'(k)}, 6);
      repeat (9 * heat_last) @(posedge core_clk);
    end
  endtask
  task automatic tc_reset;
    int n;
    send(ADDR, hti_pkg::CMD_HT_HI_SH);
    send(ADDR, hti_pkg::CMD_SOFT_RST);
    repeat (4) @(posedge core_clk);
    check(heater_on, 1'b0);
    wait_idle(n);
    check(n <= RST + 4, 1'b1);
    nack_read();
    send(ADDR, hti_pkg::CMD_MEAS_LO);
    wait_idle(n);
    send(hti_pkg::GC_ADDR, hti_pkg::GC_RESET);
    wait_idle(n);
    check(busy_last >= RST && busy_last <= RST + 4, 1'b1);
    nack_read();
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    // link reset copy needs scl edges while reset is low
    fork
      repeat (10) @(posedge core_clk);
      u_host.idle_clocks(3);
    join
    @(posedge core_clk);
    rstn <= 1'b1;
    u_host.idle_clocks(3);
    repeat (4) @(posedge core_clk);
    tc_measure();
    tc_serial();
    tc_heater();
    tc_reset();
    wrap_up();
  end
  initial
  begin
    repeat (100000) @(posedge core_clk);
    error_cnt++;
    wrap_up();
  end
endmodule
`default_nettype wire
